// file: verilog/pcs_consts.svh
// constants for the power-up clock strap and core clock source block
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH

// ==========================================================
// register byte offsets
`define PCS_OFF_STATUS 8'h00
`define PCS_OFF_CTRL 8'h04
`define PCS_OFF_RATIO 8'h08
`define PCS_OFF_IRQ 8'h0c
`define PCS_OFF_PERIOD 8'h10

// ==========================================================
// field positions
`define PCS_CTRL_FULL_BIT 0
`define PCS_ST_NOMINAL_BIT 0
`define PCS_ST_PUMP_BIT 1
`define PCS_ST_BYPASS_BIT 2
`define PCS_ST_HOLD_BIT 3
`define PCS_ST_FWD_BIT 4
`define PCS_ST_FRAME_BIT 5
`define PCS_ST_STRAP_LSB 8

// ==========================================================
// reset values
`define PCS_CTRL_RST 1'h0
`define PCS_STRAP_RST 6'h00
`define PCS_FWD_RST 1'h1

// ==========================================================
// ratio decoding and clock model figures
`define PCS_RATIO_ZERO_CODE 4'h0
`define PCS_RATIO_ZERO_DIV 5'h08
`define PCS_RATIO_MIN_DIV 5'h03
`define PCS_LOCK_SHIFT 4
`define PCS_NOM_PERIOD 8'h04
`define PCS_CLK_MHZ 25

`endif

// file: verilog/pcs_pkg.sv
// types shared by the power-up clock strap block
`default_nettype none
package pcs_pkg;

    // ==========================================================
    // reset sequencer states kept by this block
    typedef enum logic {
        PCS_WAIT_SETTLE,
        PCS_WAIT_NOMINAL
    } pcs_state_t;

    // ==========================================================
    // strap word as latched from the interrupt-request pins
    typedef struct packed {
        logic frameCopy;     // 1: internal frame clock copies divided clock
        logic fwdSampleInt;  // 1: forwarded reset sampled by internal frame
        logic [3:0] ratioCode; // core to divided clock ratio code
    } pcs_strap_t;

endpackage

`default_nettype wire

// file: verilog/pcs_tick_div.sv
// divider that turns core clock ticks into the divided clock level
`timescale 1ns/10ps
`default_nettype none

module pcs_tick_div #(
    parameter int DW = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // core tick and ratio
    input wire logic tickIn,
    input wire logic [DW-1:0] divisor,
    // divided clock level
    output logic divClk
);

    logic [DW-1:0] cnt_r;      // core ticks into current period
    logic [DW-1:0] cnt_nxt;
    logic divClk_r;            // registered divided level
    logic divClk_nxt;
    logic [DW-1:0] lastCnt;    // final count of a period
    logic [DW-1:0] halfCnt;    // ticks spent high per period

    // ==========================================================
    // next count and level
    always_comb begin
        lastCnt = divisor - {{(DW-1){1'b0}}, 1'b1};
        halfCnt = divisor >> 1;
        cnt_nxt = cnt_r;
        divClk_nxt = divClk_r;
        // advance only on a core tick
        if (tickIn) begin
            if (cnt_r >= lastCnt) begin
                cnt_nxt = '0;
            end else begin
                cnt_nxt = cnt_r + {{(DW-1){1'b0}}, 1'b1};
            end
            divClk_nxt = (cnt_nxt < halfCnt);
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_r <= '0;
            divClk_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            divClk_r <= divClk_nxt;
        end
    end

    assign divClk = divClk_r;

endmodule // pcs_tick_div

`default_nettype wire

// file: verilog/pcs_strap_clk_ctrl.sv
// power-up strap capture, core clock source select and register slave
//
// Functional notes
// R1 - power-good capture latches strap configuration
// R2 - power-good rise enables charge pump
// R3 - straps sampled at rise, core held
// R4 - afterwards pins pass as interrupt requests
// R5 - board supplies straps by weak resistors
// R6 - bypass select low: reference drives core
// R7 - divided clock kept running in bypass
// R8 - strap five selects internal frame source
// R9 - board picks frame mode by frequency
// R10 - strap four selects forwarded reset sampling
// R11 - low straps decode ratio three to sixteen
// R12 - core runs divisor times divided rate
// R13 - power-good low: settle state, nominal oscillator
// R14 - before reset release lock against reference/16
// R15 - straps stay until next power-good rise
`timescale 1ns/10ps
`default_nettype none
`include "pcs_consts.svh"

module pcs_strap_clk_ctrl
    import pcs_pkg::*;
#(
    parameter int PW = 16,  // width of the reference period counter
    parameter int DW = 5    // width of the decoded ratio
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // board side inputs
    input wire logic power_good_in,
    input wire logic board_reset_n,
    input wire logic [5:0] irq_in,
    input wire logic pll_skip_sel,
    input wire logic ref_clk_in,
    input wire logic frame_clk_in,
    input wire logic fwd_link_reset_in,
    // clock and status outputs
    output logic core_clk,
    output logic divided_clk_out,
    output logic frame_clk_int,
    output logic fwd_link_reset_int,
    output logic core_reset_hold,
    output logic pump_en_out,
    output logic [5:0] irq_req_out
);

    // ==========================================================
    // power-up state
    pcs_state_t state_r, state_nxt;   // reset sequencer position
    pcs_strap_t strap_r, strap_nxt;   // latched configuration
    logic pgPrev_r, pgPrev_nxt;       // power-good of last cycle
    logic pump_r, pump_nxt;           // charge pump enable
    logic hold_r, hold_nxt;           // core held in reset
    logic [5:0] irqOut_r, irqOut_nxt; // interrupt requests to the core
    logic pgRise;                     // power-good rising edge

    // ==========================================================
    // capture of straps on power-good and pin reuse afterwards
    always_comb begin
        pgRise = power_good_in & ~pgPrev_r;
        pgPrev_nxt = power_good_in;
        state_nxt = state_r;
        strap_nxt = strap_r;
        pump_nxt = pump_r;
        irqOut_nxt = irqOut_r;
        // R13 settle while power-good low
        if (!power_good_in) begin
            state_nxt = PCS_WAIT_SETTLE;
            pump_nxt = 1'b0;
            irqOut_nxt = '0;
        // R1 latch straps on rise
        end else if (pgRise) begin
            // R3 sampled at the rising edge
            strap_nxt = pcs_strap_t'(irq_in);
            state_nxt = PCS_WAIT_NOMINAL;
            // R2 charge pump on
            pump_nxt = 1'b1;
            irqOut_nxt = '0;
        end else begin
            // R4 pins become interrupt requests
            irqOut_nxt = irq_in;
        end
        // R3 core held during capture
        hold_nxt = ~board_reset_n | ~power_good_in | pgRise;
    end

    // R15 straps written only at rise
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= PCS_WAIT_SETTLE;
            strap_r <= pcs_strap_t'(`PCS_STRAP_RST);
            pgPrev_r <= 1'b0;
            pump_r <= 1'b0;
            hold_r <= 1'b1;
            irqOut_r <= '0;
        end else begin
            state_r <= state_nxt;
            strap_r <= strap_nxt;
            pgPrev_r <= pgPrev_nxt;
            pump_r <= pump_nxt;
            hold_r <= hold_nxt;
            irqOut_r <= irqOut_nxt;
        end
    end

    // ==========================================================
    // ratio decode
    logic [DW-1:0] divisor;  // divide factor core to divided clock

    // R11 strap code to divisor
    always_comb begin
        if (strap_r.ratioCode[3]) begin
            divisor = DW'(strap_r.ratioCode) + DW'(1);
        end else if (strap_r.ratioCode == `PCS_RATIO_ZERO_CODE) begin
            divisor = `PCS_RATIO_ZERO_DIV;
        end else if (DW'(strap_r.ratioCode) < `PCS_RATIO_MIN_DIV) begin
            // undefined codes clamp to the smallest ratio
            divisor = `PCS_RATIO_MIN_DIV;
        end else begin
            divisor = DW'(strap_r.ratioCode);
        end
    end

    // ==========================================================
    // reference clock edge and period measurement
    logic refPrev_r, refPrev_nxt;           // reference of last cycle
    logic [PW-1:0] refCnt_r, refCnt_nxt;    // cycles since last edge
    logic [PW-1:0] refPeriod_r, refPeriod_nxt; // measured period
    logic refRise;                          // reference rising edge

    // measure reference period in system cycles
    always_comb begin
        refRise = ref_clk_in & ~refPrev_r;
        refPrev_nxt = ref_clk_in;
        refPeriod_nxt = refPeriod_r;
        if (refRise) begin
            refCnt_nxt = '0;
            refPeriod_nxt = refCnt_r + PW'(1);
        end else if (&refCnt_r) begin
            // saturate on a stopped reference
            refCnt_nxt = refCnt_r;
        end else begin
            refCnt_nxt = refCnt_r + PW'(1);
        end
    end

    // registers of the measurement
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            refPrev_r <= 1'b0;
            refCnt_r <= '0;
            refPeriod_r <= '0;
        end else begin
            refPrev_r <= refPrev_nxt;
            refCnt_r <= refCnt_nxt;
            refPeriod_r <= refPeriod_nxt;
        end
    end

    // ==========================================================
    // phase-locked loop model and core clock select
    logic [PW+3:0] acc_r, acc_nxt;  // phase accumulator
    logic [PW+3:0] target;          // accumulator wrap value
    logic [PW+3:0] step;            // accumulator increment
    logic [PW+3:0] sum;             // accumulator plus step
    logic pllTick;                  // one oscillator period elapsed
    logic coreTick_r, coreTick_nxt; // registered core clock tick
    logic ctrlFull_r, ctrlFull_nxt; // software full-ratio lock request
    logic lockFull;                 // full-ratio lock in effect

    // oscillator rate from lock target and divisor
    always_comb begin
        // R14 divided-by-16 lock until reset released with full-ratio lock requested
        lockFull = ctrlFull_r & board_reset_n;
        // R13 nominal speed without charge pump
        target = (PW+4)'(`PCS_NOM_PERIOD);
        step = (PW+4)'(1);
        if (pump_r && refPeriod_r != '0) begin
            // R12 divisor core ticks per lock period
            step = (PW+4)'(divisor);
            if (lockFull) begin
                target = (PW+4)'(refPeriod_r);
            end else begin
                target = (PW+4)'(refPeriod_r) << `PCS_LOCK_SHIFT;
            end
        end
        sum = acc_r + step;
        pllTick = 1'b0;
        acc_nxt = sum;
        if (sum >= target) begin
            acc_nxt = sum - target;
            pllTick = 1'b1;
        end
        // R12 phase align to reference at full speed
        if (pump_r && lockFull && refRise) begin
            acc_nxt = '0;
            pllTick = 1'b1;
        end
        // R6 select source from bypass input
        if (pll_skip_sel) begin
            coreTick_nxt = pllTick;
        end else begin
            coreTick_nxt = refRise;
        end
    end

    // registers of the clock model
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_r <= '0;
            coreTick_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            coreTick_r <= coreTick_nxt;
        end
    end

    // ==========================================================
    // divided clock output
    logic divClk;  // divided clock level

    // R7 divider runs in both source modes
    pcs_tick_div #(
        .DW(DW)
    ) u_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .tickIn(coreTick_r),
        .divisor(divisor),
        .divClk(divClk)
    );

    // ==========================================================
    // internal frame clock and forwarded reset
    logic frameExt_r, frameExt_nxt;     // sampled external frame clock
    logic frameExtPrev_r;               // external frame one cycle back
    logic frameInt_r, frameInt_nxt;     // internal frame clock
    logic frameIntPrev_r;               // internal frame one cycle back
    logic fwdInt_r, fwdInt_nxt;         // internal forwarded reset
    logic sampleEdge;                   // chosen frame rising edge

    // frame source and reset sampling choice
    always_comb begin
        frameExt_nxt = frame_clk_in;
        // R8 frame source from strap five
        if (strap_r.frameCopy) begin
            frameInt_nxt = divClk;
        end else begin
            frameInt_nxt = frameExt_r;
        end
        // R10 sampling clock from strap four
        if (strap_r.fwdSampleInt) begin
            sampleEdge = frameInt_r & ~frameIntPrev_r;
        end else begin
            sampleEdge = frameExt_r & ~frameExtPrev_r;
        end
        fwdInt_nxt = sampleEdge ? fwd_link_reset_in : fwdInt_r;
    end

    // registers of the frame logic
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            frameExt_r <= 1'b0;
            frameExtPrev_r <= 1'b0;
            frameInt_r <= 1'b0;
            frameIntPrev_r <= 1'b0;
            fwdInt_r <= `PCS_FWD_RST;
        end else begin
            frameExt_r <= frameExt_nxt;
            frameExtPrev_r <= frameExt_r;
            frameInt_r <= frameInt_nxt;
            frameIntPrev_r <= frameInt_r;
            fwdInt_r <= fwdInt_nxt;
        end
    end

    // ==========================================================
    // apb register slave
    logic [31:0] prdata_r, prdata_nxt; // read data for access phase
    logic pready_r, pready_nxt;        // ready in access phase
    logic pslverr_r, pslverr_nxt;      // error on unmapped address
    logic [31:0] rdMux;                // addressed register value
    logic hit;                         // address is mapped
    logic setup;                       // setup phase of a transfer

    // decode, read mux and control write
    always_comb begin
        setup = psel & ~penable;
        rdMux = '0;
        hit = 1'b1;
        unique case (paddr)
            `PCS_OFF_STATUS: begin
                rdMux[`PCS_ST_NOMINAL_BIT] = (state_r == PCS_WAIT_NOMINAL);
                rdMux[`PCS_ST_PUMP_BIT] = pump_r;
                rdMux[`PCS_ST_BYPASS_BIT] = ~pll_skip_sel;
                rdMux[`PCS_ST_HOLD_BIT] = hold_r;
                rdMux[`PCS_ST_FWD_BIT] = fwdInt_r;
                rdMux[`PCS_ST_FRAME_BIT] = frameInt_r;
                rdMux[`PCS_ST_STRAP_LSB +: 6] = strap_r;
            end
            `PCS_OFF_CTRL: begin
                rdMux[`PCS_CTRL_FULL_BIT] = ctrlFull_r;
            end
            `PCS_OFF_RATIO: begin
                rdMux = 32'(divisor);
            end
            `PCS_OFF_IRQ: begin
                rdMux = 32'(irqOut_r);
            end
            `PCS_OFF_PERIOD: begin
                rdMux = 32'(refPeriod_r);
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        pready_nxt = setup;
        pslverr_nxt = setup & ~hit;
        prdata_nxt = prdata_r;
        if (setup) begin
            prdata_nxt = pwrite ? 32'h0000_0000 : rdMux;
        end
        ctrlFull_nxt = ctrlFull_r;
        // write takes effect at the completing edge
        if (psel && penable && pready_r && pwrite &&
            paddr == `PCS_OFF_CTRL) begin
            ctrlFull_nxt = pwdata[`PCS_CTRL_FULL_BIT];
        end
    end

    // registers of the slave
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            ctrlFull_r <= `PCS_CTRL_RST;
        end else begin
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            ctrlFull_r <= ctrlFull_nxt;
        end
    end

    // ==========================================================
    // outputs, all from flip-flops
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign core_clk = coreTick_r;
    assign divided_clk_out = divClk;
    assign frame_clk_int = frameInt_r;
    assign fwd_link_reset_int = fwdInt_r;
    assign core_reset_hold = hold_r;
    assign pump_en_out = pump_r;
    assign irq_req_out = irqOut_r;

endmodule // pcs_strap_clk_ctrl

`default_nettype wire

// file: verification/pcs_board_model.sv
// board model: reference and frame clocks, strap resistors, requests
`timescale 1ns/10ps
`default_nettype none

module pcs_board_model (
    // clock
    input wire logic clk,
    // bench control of straps and requests
    input wire logic strapDrive,
    input wire logic [5:0] strapVal,
    input wire logic [5:0] reqVal,
    // board lines into the block
    output logic ref_clk_in,
    output logic frame_clk_in,
    output logic [5:0] irq_in
);
    // ==========================================================
    // divider chain for the two board clocks
    logic [3:0] cnt_r = 4'h0; // free running count
    logic [3:0] cnt_nxt; // next count

    // advance the count each cycle
    always_comb begin
        cnt_nxt = cnt_r + 4'h1;
    end

    // register the count
    always_ff @(posedge clk) begin
        cnt_r <= cnt_nxt;
    end

    assign ref_clk_in = cnt_r[2];
    // frame held static when copy mode is strapped
    assign frame_clk_in = strapVal[5] ? 1'b0 : cnt_r[3];

    assign irq_in = strapDrive ? strapVal : reqVal;
endmodule // pcs_board_model

`default_nettype wire

// file: verification/pcs_strap_monitor.sv
// checker for the strap capture and clock select ports
`timescale 1ns/10ps
`default_nettype none

module pcs_strap_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // board inputs
    input wire logic power_good_in,
    input wire logic [5:0] irq_in,
    input wire logic pll_skip_sel,
    input wire logic ref_clk_in,
    // block outputs
    input wire logic core_clk,
    input wire logic divided_clk_out,
    input wire logic core_reset_hold,
    input wire logic pump_en_out,
    input wire logic [5:0] irq_req_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // steps of the watched behaviour
    sequence pgRise;
        power_good_in && !$past(power_good_in) && !$past(sys_rst);
    endsequence
    sequence bypRise;
        $rose(ref_clk_in) && !pll_skip_sel ##1 !pll_skip_sel [*4];
    endsequence

    // ==========================================================
    // power-good capture and hold
    chk_pump_on_rise: assert property (pgRise |=> pump_en_out)
        else $error("pump not enabled after power-good rise");
    chk_pump_off_low: assert property (!power_good_in |=> !pump_en_out)
        else $error("pump still on with power-good low");
    chk_hold_pg_low: assert property (!power_good_in |=> core_reset_hold)
        else $error("core not held with power-good low");
    chk_hold_at_rise: assert property (pgRise |=> core_reset_hold)
        else $error("core not held at strap sampling");
    chk_irq_pass_on: assert property (
        power_good_in && $past(power_good_in) && !$past(sys_rst)
        |=> irq_req_out == $past(irq_in))
        else $error("request pins not passed through");
    chk_irq_quiet_low: assert property (
        !power_good_in |=> irq_req_out == 6'h00)
        else $error("requests passed with power-good low");

    // ==========================================================
    // clock source
    chk_bypass_core_tick: assert property (bypRise |-> core_clk ||
        $past(core_clk) || $past(core_clk, 2) || $past(core_clk, 3))
        else $error("no core tick after reference rise in bypass");
    chk_div_runs_byp: assert property (
        (!pll_skip_sel && power_good_in) [*8] |-> ##[0:300]
        ($changed(divided_clk_out) || pll_skip_sel || !power_good_in))
        else $error("divided clock stopped in bypass");
endmodule // pcs_strap_monitor

bind pcs_strap_clk_ctrl pcs_strap_monitor u_mon (
    .clk, .sys_rst, .power_good_in, .irq_in, .pll_skip_sel, .ref_clk_in,
    .core_clk, .divided_clk_out, .core_reset_hold, .pump_en_out,
    .irq_req_out
);

`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench for the strap capture and clock select block
`timescale 1ns/10ps
`default_nettype none
`include "pcs_consts.svh"

module tb_top;
    // ==========================================================
    // signals
    logic clk = 1'b0, sys_rst = 1'b1; // clock and reset
    logic [7:0] paddr = 8'h00; // apb request
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr; // apb answer
    logic power_good_in = 1'b0, board_reset_n = 1'b0; // board levels
    logic pll_skip_sel = 1'b0, fwd_link_reset_in = 1'b1;
    logic strapDrive = 1'b1; // straps on the pins
    logic [5:0] strapVal = 6'h00, reqVal = 6'h00, irq_in, irq_req_out;
    logic ref_clk_in, frame_clk_in, core_clk, divided_clk_out;
    logic frame_clk_int, fwd_link_reset_int, core_reset_hold, pump_en_out;
    int fail_count = 0, checks_done = 0; // tallies

    pcs_board_model board (.clk, .strapDrive, .strapVal, .reqVal,
        .ref_clk_in, .frame_clk_in, .irq_in);
    pcs_strap_clk_ctrl dut (.clk, .sys_rst, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .power_good_in,
        .board_reset_n, .irq_in, .pll_skip_sel, .ref_clk_in, .frame_clk_in,
        .fwd_link_reset_in, .core_clk, .divided_clk_out, .frame_clk_int,
        .fwd_link_reset_int, .core_reset_hold, .pump_en_out, .irq_req_out);

    // 25 MHz clock
    initial forever #20 clk = ~clk;

    // ==========================================================
    // reporting and comparison
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic bad(input string m);
        fail_count++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic cmp(input logic [31:0] g, e, input string m);
        checks_done++;
        if (g !== e) bad(m);
    endtask
    task automatic near(input int g, e, tol, input string m);
        checks_done++;
        if (g < e - tol || g > e + tol) bad(m);
    endtask

    // ==========================================================
    // apb transfer, idle cycle after it
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        psel <= 1'b1;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad("apb timeout");
            tally_and_finish();
        end
        @(posedge clk);
    endtask
    // read, masked compare, error expected above the last offset
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, msk);
        logic [31:0] d;
        logic err;
        apb(1'b0, a, 32'h0, d, err);
        cmp(d & msk, e, "read data");
        cmp({31'h0, err}, {31'h0, a > 8'h10}, "read error");
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] d;
        logic err;
        apb(1'b1, a, v, d, err);
        cmp({31'h0, err}, 32'h0, "write error");
    endtask

    // ==========================================================
    // board actions and measurement
    task automatic capture(input logic [5:0] s);
        power_good_in <= 1'b0;
        strapDrive <= 1'b1;
        strapVal <= s;
        repeat (4) @(posedge clk);
        power_good_in <= 1'b1;
        repeat (2) @(posedge clk);
        strapDrive <= 1'b0;
    endtask
    // expected divisor of ratio code 0 or 3 to 15
    function automatic int divOf(input logic [3:0] c);
        return c == 4'h0 ? 8 : c < 4'h8 ? int'(c) : int'(c) + 1;
    endfunction
    // count core ticks and rises of divided and frame clocks
    task automatic measure(input int n, output int nc, nd, nf);
        logic pd;
        logic pf;
        nc = 0;
        nd = 0;
        nf = 0;
        repeat (n) begin
            pd = divided_clk_out;
            pf = frame_clk_int;
            @(posedge clk);
            nc += int'(core_clk === 1'b1);
            nd += int'(divided_clk_out === 1'b1 && pd === 1'b0);
            nf += int'(frame_clk_int === 1'b1 && pf === 1'b0);
        end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        logic [5:0] s;
        logic [3:0] c;
        int nc, nd, nf;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        // reset values, control bit, unmapped place
        rdchk(`PCS_OFF_STATUS, 32'h1c, 32'h3f1f);
        rdchk(`PCS_OFF_CTRL, 32'h0, 32'h1);
        rdchk(`PCS_OFF_RATIO, 32'h8, 32'h1f);
        rdchk(8'h40, 32'h0, 32'hffffffff);
        wr(`PCS_OFF_CTRL, 32'h1);
        rdchk(`PCS_OFF_CTRL, 32'h1, 32'h1);
        wr(`PCS_OFF_CTRL, 32'h0);
        // ratio codes 0 and 3 to 15, upper straps cycled
        for (int i = 0; i < 14; i++) begin
            c = i < 5 ? 4'(i + 3) : i == 5 ? 4'h0 : 4'(i + 2);
            s = {2'(i), c};
            capture(s);
            if (i == 13) wr(`PCS_OFF_RATIO, 32'h1f);
            rdchk(`PCS_OFF_RATIO, 32'(divOf(c)), 32'h1f);
            rdchk(`PCS_OFF_STATUS, {18'h0, s, 8'h0f}, 32'h3f0f);
        end
        // later pin activity is request traffic only
        reqVal <= 6'h2a;
        repeat (3) @(posedge clk);
        rdchk(`PCS_OFF_IRQ, 32'h2a, 32'h3f);
        rdchk(`PCS_OFF_STATUS, {18'h0, s, 8'h0}, 32'h3f00);
        // bypass, frame copy, internal sampling, divisor four
        capture(6'h34);
        fwd_link_reset_in <= 1'b0;
        measure(320, nc, nd, nf);
        near(nc, 40, 2, "bypass core rate");
        near(nd, 10, 1, "bypass divided rate");
        near(nf, 10, 1, "frame copy rate");
        rdchk(`PCS_OFF_STATUS, 32'h0, 32'h10);
        cmp({31'h0, fwd_link_reset_int}, 32'h0, "fwd reset low");
        // bypass, sampled frame, external sampling, divisor three
        capture(6'h03);
        fwd_link_reset_in <= 1'b1;
        measure(320, nc, nd, nf);
        near(nd, 13, 1, "divisor three rate");
        near(nf, 20, 1, "sampled frame rate");
        rdchk(`PCS_OFF_STATUS, 32'h10, 32'h10);
        cmp({31'h0, fwd_link_reset_int}, 32'h1, "fwd reset high");
        // pll in use, lock against reference over sixteen
        pll_skip_sel <= 1'b1;
        capture(6'h34);
        repeat (40) @(posedge clk);
        rdchk(`PCS_OFF_PERIOD, 32'h8, 32'hffff);
        rdchk(`PCS_OFF_STATUS, 32'h0b, 32'h0f);
        // full lock requested, but board reset still holds the reduced lock
        wr(`PCS_OFF_CTRL, 32'h1);
        measure(512, nc, nd, nf);
        near(nc, 16, 2, "reduced lock rate");
        // full rate after board reset release
        board_reset_n <= 1'b1;
        repeat (40) @(posedge clk);
        measure(256, nc, nd, nf);
        near(nc, 128, 4, "full core rate");
        near(nd, 32, 2, "full divided rate");
        rdchk(`PCS_OFF_STATUS, 32'h0, 32'h08);
        // power-good dropped
        power_good_in <= 1'b0;
        repeat (3) @(posedge clk);
        rdchk(`PCS_OFF_STATUS, 32'h08, 32'h0b);
        rdchk(`PCS_OFF_IRQ, 32'h0, 32'h3f);
        tally_and_finish();
    end
endmodule // tb_top

`default_nettype wire
